//--- rtl/sgw_pkg.sv
// Shared constants, states and carriers of the configuration port block
package sgw_pkg;
    // Host port addresses; the strap picks the low or high pair
    localparam logic [15:0] PORT_INDEX_LO = 16'h002e;
    localparam logic [15:0] PORT_DATA_LO = 16'h002f;
    localparam logic [15:0] PORT_INDEX_HI = 16'h004e;
    localparam logic [15:0] PORT_DATA_HI = 16'h004f;
    // Keys written to the index port
    localparam logic [7:0] KEY_UNLOCK = 8'h87;
    localparam logic [7:0] KEY_LOCK = 8'haa;
    // Register indices and logical device numbers
    localparam logic [7:0] IDX_LDN = 8'h07;
    localparam logic [7:0] LDN_GPIO = 8'h07;
    localparam logic [7:0] LDN_WDT = 8'h08;
    localparam logic [7:0] IDX_GPIO_DIR = 8'hf0;
    localparam logic [7:0] IDX_GPIO_DATA = 8'hf1;
    localparam logic [7:0] IDX_GPIO_INV = 8'hf2;
    localparam logic [7:0] IDX_WDT_ACT = 8'h30;
    localparam logic [7:0] IDX_WDT_TMO = 8'hf6;
    localparam int unsigned WDT_ACT_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_GPIO_DIR = 8'hff;
    localparam logic [7:0] RST_GPIO_DATA = 8'h00;
    localparam logic [7:0] RST_GPIO_INV = 8'h00;
    localparam logic [7:0] RST_LDN = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_WDT_TMO = 8'h00;
    // Value seen on reads that carry no configuration content
    localparam logic [7:0] READ_IDLE = 8'hff;
    localparam logic [1:0] STRAP_WAIT = 2'd2;
    // Timing
    localparam longint unsigned CLK_HZ = 64'd40_000_000;
    localparam longint unsigned WDT_TICK_S = 64'd1;
    localparam int unsigned WDT_TICK_CYCLES = int'(CLK_HZ * WDT_TICK_S);
    localparam longint unsigned CLK_PERIOD_NS = 64'd1_000_000_000 / CLK_HZ;
    localparam longint unsigned WDT_RST_NS = 64'd1000;
    localparam int unsigned WDT_RST_CYCLES =
        int'((WDT_RST_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);

    // Unlock sequencer states
    typedef enum logic [2:0] {
        SGW_LOCKED = 3'b001,
        SGW_HALF = 3'b010,
        SGW_OPEN = 3'b100
    } sgw_mode_e;

    // One host I/O cycle, valid for the single clock it is strobed
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sgw_io_req_s;
endpackage

//--- rtl/sgw_wdt.sv
// Watchdog counter that pulses the CPU reset on expiry
module sgw_wdt #(
    parameter int unsigned TICK_CYCLES = sgw_pkg::WDT_TICK_CYCLES,
    parameter int unsigned RST_CYCLES = sgw_pkg::WDT_RST_CYCLES
) (
    input wire logic clock, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic enable, // Watchdog activated
    input wire logic load, // Reload pulse
    input wire logic [7:0] load_val, // Timeout byte, two BCD digits
    output logic cpu_rst // CPU reset, active high
);
    import sgw_pkg::*;

    logic [31:0] tick_r;
    logic [7:0] cnt_r;
    logic expired_r;
    logic [31:0] rst_cnt_r;
    logic fire;

    if (TICK_CYCLES < 2 || RST_CYCLES < 1) begin : g_bad_param
        $error("sgw_wdt needs TICK_CYCLES >= 2 and RST_CYCLES >= 1");
    end

    // Timeout byte reads as decimal seconds so 20h gives twenty
    function automatic logic [7:0] bcd_secs(input logic [7:0] v);
        logic [7:0] tens;
        tens = {4'h0, v[7:4]};
        bcd_secs = 8'((tens << 3) + (tens << 1) + {4'h0, v[3:0]});
    endfunction

    assign fire = enable && !expired_r && !load && cnt_r == 8'h00;

    // Second counter; holds while disabled, one shot per expiry
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tick_r <= 32'h0;
            cnt_r <= 8'h00;
            expired_r <= 1'b0;
        end else if (load) begin
            tick_r <= 32'h0;
            cnt_r <= bcd_secs(load_val);
            expired_r <= 1'b0;
        end else if (!enable) begin
            tick_r <= 32'h0;
        end else if (fire) begin
            expired_r <= 1'b1;
        end else if (!expired_r) begin
            if (tick_r == TICK_CYCLES - 1) begin
                tick_r <= 32'h0;
                cnt_r <= cnt_r - 8'h01;
            end else begin
                tick_r <= tick_r + 32'h1;
            end
        end
    end

    // Reset pulse of fixed width so the CPU sees a clean reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_r <= 32'h0;
            cpu_rst <= 1'b0;
        end else if (fire) begin
            rst_cnt_r <= RST_CYCLES - 1;
            cpu_rst <= 1'b1;
        end else if (rst_cnt_r != 32'h0) begin
            rst_cnt_r <= rst_cnt_r - 32'h1;
        end else begin
            cpu_rst <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_expiry_fires: assert property (fire |=> cpu_rst && expired_r)
        else $error("expired watchdog did not reset the CPU");
    a_reset_cause: assert property ($rose(cpu_rst) |-> $past(fire))
        else $error("CPU reset without watchdog expiry");
    a_reload_count: assert property (load |=> cnt_r ==
        bcd_secs($past(load_val)) && !expired_r)
        else $error("timeout write did not reload the counter");
    a_no_fire_off: assert property (!enable |=> !$rose(cpu_rst))
        else $error("disabled watchdog reset the CPU");
    c_expiry: cover property ($rose(cpu_rst));
endmodule

//--- rtl/sgw_cfg.sv
// Configuration port with keyed unlock, GPIO bank and watchdog
// What this block does
// - Two consecutive unlock keys on the index port open configuration mode.
// - The lock key on the index port closes configuration mode.
// - Write-only index port at one of two strapped addresses selects register.
// - Data port at one of two addresses reaches the indexed register.
// - Index 07h holds the logical device number that selects the bank.
// - Device 7 holds GPIO direction, data and inversion at F0, F1, F2.
// - Direction bit one means input, zero output; resets to all ones.
// - Data bits writable for outputs only, read-only for inputs; reset zero.
// - Inversion bit flips sampled input and driven output; resets to zero.
// - Device 8 activation register at 30h: 01h enables, 00h disables watchdog.
// - Watchdog timeout loads through index F6h; 20h means twenty seconds.
// - An expired enabled watchdog asserts a reset to the CPU.
module sgw_cfg #(
    parameter int unsigned TICK_CYCLES = sgw_pkg::WDT_TICK_CYCLES,
    parameter int unsigned RST_CYCLES = sgw_pkg::WDT_RST_CYCLES
) (
    input wire logic clock, // System clock, 40 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire sgw_pkg::sgw_io_req_s io_req, // Host I/O cycle strobe
    output logic [7:0] io_rdata, // Read data
    output logic io_rvalid, // Read data valid, one cycle
    input wire logic base_sel, // Strap: high selects 4Eh/4Fh pair
    input wire logic [7:0] gpio_in, // GPIO pin levels
    output logic [7:0] gpio_out, // GPIO driven levels
    output logic [7:0] gpio_oe, // GPIO output enables, high drives
    output logic cpu_rst // CPU reset from the watchdog
);
    import sgw_pkg::*;

    sgw_mode_e mode_r;
    logic [7:0] index_r, ldn_r, dir_r, data_r, inv_r, tmo_r;
    logic act_r;
    logic [7:0] gpio_s1_r, gpio_s2_r;
    logic sel_s1_r, sel_s2_r, base_hi_r, strap_done_r;
    logic [1:0] strap_cnt_r;
    logic idx_hit, dat_hit, cfg_open, wr_idx, wr_dat, rd_any;
    logic [7:0] wdat, gpio_rd, rd_val, pin_nxt;
    logic wdt_load;
    logic [7:0] wdt_load_val;

    // True when the current data port access targets that device register
    function automatic logic reg_is(input logic [7:0] logical_device_number,
                                    input logic [7:0] idx,
                                    input logic [7:0] want_ldn,
                                    input logic [7:0] want_idx);
        reg_is = logical_device_number == want_ldn && idx == want_idx;
    endfunction

    // Strap and pins cross in through two flops before any use
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
            gpio_s1_r <= 8'h00;
            gpio_s2_r <= 8'h00;
        end else begin
            sel_s1_r <= base_sel;
            sel_s2_r <= sel_s1_r;
            gpio_s1_r <= gpio_in;
            gpio_s2_r <= gpio_s1_r;
        end
    end

    // Strap latched once after release, once the synchroniser settles
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strap_cnt_r <= 2'd0;
            strap_done_r <= 1'b0;
            base_hi_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'd1;
            if (strap_cnt_r == STRAP_WAIT) begin
                base_hi_r <= sel_s2_r;
                strap_done_r <= 1'b1;
            end
        end
    end

    // Port decode and access qualification
    always_comb begin
        wdat = io_req.wdata;
        idx_hit = strap_done_r &&
            io_req.addr == (base_hi_r ? PORT_INDEX_HI : PORT_INDEX_LO);
        dat_hit = strap_done_r &&
            io_req.addr == (base_hi_r ? PORT_DATA_HI : PORT_DATA_LO);
        cfg_open = mode_r == SGW_OPEN;
        wr_idx = io_req.wr && idx_hit;
        wr_dat = io_req.wr && dat_hit && cfg_open;
        rd_any = io_req.rd && (idx_hit || dat_hit);
    end

    // Unlock sequencer; any other index write breaks a half sequence
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= SGW_LOCKED;
        end else if (wr_idx) begin
            unique case (mode_r)
                SGW_LOCKED: begin
                    if (wdat == KEY_UNLOCK) mode_r <= SGW_HALF;
                end
                SGW_HALF: begin
                    mode_r <= (wdat == KEY_UNLOCK) ? SGW_OPEN : SGW_LOCKED;
                end
                SGW_OPEN: begin
                    if (wdat == KEY_LOCK) mode_r <= SGW_LOCKED;
                end
                default: mode_r <= SGW_LOCKED;
            endcase
        end
    end

    // Index register only moves while open, the lock key is not stored
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            index_r <= RST_INDEX;
        end else if (wr_idx && cfg_open && wdat != KEY_LOCK) begin
            index_r <= wdat;
        end
    end

    // Logical device number
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ldn_r <= RST_LDN;
        end else if (wr_dat && index_r == IDX_LDN) begin
            ldn_r <= wdat;
        end
    end

    // GPIO bank in device 7
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dir_r <= RST_GPIO_DIR;
            data_r <= RST_GPIO_DATA;
            inv_r <= RST_GPIO_INV;
        end else if (wr_dat) begin
            if (reg_is(ldn_r, index_r, LDN_GPIO, IDX_GPIO_DIR))
                dir_r <= wdat;
            if (reg_is(ldn_r, index_r, LDN_GPIO, IDX_GPIO_DATA))
                data_r <= (wdat & ~dir_r) | (data_r & dir_r);
            if (reg_is(ldn_r, index_r, LDN_GPIO, IDX_GPIO_INV))
                inv_r <= wdat;
        end
    end

    // Watchdog registers in device 8; only bit 0 steers activation
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            act_r <= 1'b0;
            tmo_r <= RST_WDT_TMO;
        end else if (wr_dat) begin
            if (reg_is(ldn_r, index_r, LDN_WDT, IDX_WDT_ACT))
                act_r <= wdat[WDT_ACT_BIT];
            if (reg_is(ldn_r, index_r, LDN_WDT, IDX_WDT_TMO))
                tmo_r <= wdat;
        end
    end

    // Reload on timeout write, and on enable so a stale count cannot fire
    always_comb begin
        wdt_load = 1'b0;
        wdt_load_val = tmo_r;
        if (wr_dat && reg_is(ldn_r, index_r, LDN_WDT, IDX_WDT_TMO)) begin
            wdt_load = 1'b1;
            wdt_load_val = wdat;
        end else if (wr_dat && !act_r && wdat[WDT_ACT_BIT] &&
                     reg_is(ldn_r, index_r, LDN_WDT, IDX_WDT_ACT)) begin
            wdt_load = 1'b1;
        end
    end

    sgw_wdt #(
        .TICK_CYCLES(TICK_CYCLES),
        .RST_CYCLES(RST_CYCLES)
    ) u_wdt (
        .clock(clock),
        .arst_n(arst_n),
        .enable(act_r),
        .load(wdt_load),
        .load_val(wdt_load_val),
        .cpu_rst(cpu_rst)
    );

    // Read view: inputs show the inverted pin, outputs the data bit
    always_comb begin
        gpio_rd = ((gpio_s2_r ^ inv_r) & dir_r) | (data_r & ~dir_r);
        pin_nxt = data_r ^ inv_r;
        rd_val = 8'h00;
        if (index_r == IDX_LDN) begin
            rd_val = ldn_r;
        end else if (ldn_r == LDN_GPIO) begin
            unique case (index_r)
                IDX_GPIO_DIR: rd_val = dir_r;
                IDX_GPIO_DATA: rd_val = gpio_rd;
                IDX_GPIO_INV: rd_val = inv_r;
                default: rd_val = 8'h00;
            endcase
        end else if (ldn_r == LDN_WDT) begin
            if (index_r == IDX_WDT_ACT) rd_val = {7'h00, act_r};
            else if (index_r == IDX_WDT_TMO) rd_val = tmo_r;
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= READ_IDLE;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= rd_any;
            if (rd_any) begin
                io_rdata <= (dat_hit && cfg_open) ? rd_val : READ_IDLE;
            end
        end
    end

    // Pins registered so outputs come from flops; one cycle behind
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gpio_out <= RST_GPIO_DATA;
            gpio_oe <= 8'h00;
        end else begin
            gpio_out <= pin_nxt;
            gpio_oe <= ~dir_r;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_unlock_keys: assert property ($rose(cfg_open) |->
        $past(wr_idx && wdat == KEY_UNLOCK) &&
        $past(mode_r == SGW_HALF))
        else $error("configuration opened without two keys");
    a_lock_key: assert property (wr_idx && cfg_open && wdat == KEY_LOCK
        |=> mode_r == SGW_LOCKED)
        else $error("lock key did not close configuration");
    a_index_store: assert property (wr_idx && cfg_open && wdat != KEY_LOCK
        |=> index_r == $past(wdat))
        else $error("index write not stored");
    a_ldn_select: assert property (wr_dat && index_r == IDX_LDN
        |=> ldn_r == $past(wdat))
        else $error("device number not stored");
    a_dir_read: assert property (io_req.rd && dat_hit && cfg_open &&
        reg_is(ldn_r, index_r, LDN_GPIO, IDX_GPIO_DIR)
        |=> io_rvalid && io_rdata == $past(dir_r))
        else $error("direction read returned wrong value");
    a_oe_dir: assert property (##1 gpio_oe == ~$past(dir_r))
        else $error("output enable does not follow direction");
    a_input_kept: assert property (wr_dat &&
        reg_is(ldn_r, index_r, LDN_GPIO, IDX_GPIO_DATA)
        |=> (data_r & $past(dir_r)) == ($past(data_r) & $past(dir_r)))
        else $error("write changed an input data bit");
    a_pin_invert: assert property (##1 gpio_out == $past(pin_nxt))
        else $error("driven level ignores inversion");
    a_wdt_enable: assert property (wr_dat &&
        reg_is(ldn_r, index_r, LDN_WDT, IDX_WDT_ACT)
        |=> act_r == $past(wdat[WDT_ACT_BIT]))
        else $error("activation write not applied");
    a_locked_quiet: assert property (!cfg_open |=>
        $stable(dir_r) && $stable(data_r) && $stable(inv_r) &&
        $stable(ldn_r) && $stable(act_r) && $stable(tmo_r))
        else $error("locked access changed a register");
    a_locked_read: assert property (io_rvalid && $past(!cfg_open)
        |-> io_rdata == READ_IDLE)
        else $error("locked read leaked configuration data");

    c_unlock: cover property ($rose(cfg_open));
    c_gpio_write: cover property (wr_dat &&
        reg_is(ldn_r, index_r, LDN_GPIO, IDX_GPIO_DATA));
    c_wdt_on: cover property ($rose(act_r));
    c_relock: cover property ($fell(cfg_open));
endmodule

//--- dv/sgw_host.sv
// Host model that issues byte I/O cycles to the configuration port
module sgw_host (
    input wire logic clock, // System clock
    input wire logic base_sel, // Strap, high picks the 4Eh/4Fh pair
    input wire logic [7:0] io_rdata, // Read data from the device
    input wire logic io_rvalid, // Read answer strobe
    output sgw_pkg::sgw_io_req_s io_req // I/O cycle to the device
);
    timeunit 1ns;
    timeprecision 1ps;
    import sgw_pkg::*;
    logic [15:0] ip;
    logic [15:0] dp;
    // Ports follow the same strap the device samples
    assign ip = base_sel ? PORT_INDEX_HI : PORT_INDEX_LO;
    assign dp = base_sel ? PORT_DATA_HI : PORT_DATA_LO;
    initial io_req = '0;
    // One strobe cycle; afterwards address and data are scrambled, not held
    task automatic cyc(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(negedge clock);
        io_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge clock);
        io_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1'b1, a, d);
    endtask
    // Answer comes one cycle after the strobe edge, seen at this low phase
    task automatic rd(input logic [15:0] a, output logic [7:0] d,
                      output logic v);
        cyc(1'b0, a, 8'h00);
        d = io_rdata;
        v = io_rvalid;
    endtask
    task automatic unlock();
        wr(ip, KEY_UNLOCK);
        wr(ip, KEY_UNLOCK);
    endtask
    task automatic lock();
        wr(ip, KEY_LOCK);
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
        wr(ip, idx);
        wr(dp, val);
    endtask
    task automatic rreg(input logic [7:0] idx, output logic [7:0] d);
        logic v;
        wr(ip, idx);
        rd(dp, d, v);
    endtask
    task automatic logical_device_number(input logic [7:0] n);
        wreg(IDX_LDN, n);
    endtask
endmodule

//--- dv/tb_superio_gpio_watchdog_config.sv
// Self-checking bench for the configuration port block
module tb_superio_gpio_watchdog_config;
    timeunit 1ns;
    timeprecision 1ps;
    import sgw_pkg::*;
    localparam int TICK = 4;
    localparam int RSTC = 4;
    typedef struct packed {
        logic [7:0] dir, inv, dw, pin, oe, out, rd;
    } sgw_row_s;
    logic clock, arst_n, base_sel, hi, v;
    logic [7:0] gpio_in, gpio_out, gpio_oe, io_rdata, d;
    logic io_rvalid, cpu_rst;
    sgw_io_req_s io_req;
    int err_count, checks, n;
    // Stored data is dw with output bits forced by the later ff write
    sgw_row_s rows [4] = '{
        '{8'hff, 8'h00, 8'h5a, 8'h3c, 8'h00, 8'h5a, 8'h3c},
        '{8'h00, 8'h0f, 8'h12, 8'h00, 8'hff, 8'hf0, 8'hff},
        '{8'hf0, 8'h33, 8'ha5, 8'h96, 8'h0f, 8'h9c, 8'haf},
        '{8'h0f, 8'hc3, 8'h00, 8'hff, 8'hf0, 8'h33, 8'hfc}};
    sgw_cfg #(.TICK_CYCLES(TICK), .RST_CYCLES(RSTC)) dut (
        .clock(clock), .arst_n(arst_n), .io_req(io_req),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .base_sel(base_sel),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .cpu_rst(cpu_rst));
    sgw_host host (
        .clock(clock), .base_sel(base_sel), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .io_req(io_req));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Strap is sampled a few edges after release, so leave a margin
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (12) @(negedge clock);
        arst_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask
    // Bounded wait for a watchdog level; running out ends the run
    task automatic wait_rst(input logic lvl, input int lim, output int k);
        k = 0;
        while (cpu_rst !== lvl) begin
            @(negedge clock);
            k++;
            if (k > lim) begin
                err_count++;
                $display("mismatch at %0t: watchdog wait ran out", $time);
                close_out();
            end
        end
    endtask
    task automatic quiet(input int cyc);
        hi = 1'b0;
        repeat (cyc) begin
            @(negedge clock);
            hi = hi | cpu_rst;
        end
    endtask
    initial begin
        arst_n = 1'b0;
        base_sel = 1'b0;
        gpio_in = 8'h00;
        err_count = 0;
        checks = 0;
        do_reset();
        check(gpio_oe, 8'h00);
        check(gpio_out, 8'h00);
        check({7'b0, cpu_rst}, 8'h00);
        host.rd(PORT_DATA_LO, d, v);
        check(d, READ_IDLE);
        check({7'b0, v}, 8'h01);
        // Interrupted key pair must not open the port
        host.wr(PORT_INDEX_LO, KEY_UNLOCK);
        host.wr(PORT_INDEX_LO, IDX_LDN);
        host.wr(PORT_INDEX_LO, KEY_UNLOCK);
        host.rd(PORT_DATA_LO, d, v);
        check(d, READ_IDLE);
        host.wr(PORT_INDEX_LO, KEY_UNLOCK);
        host.logical_device_number(LDN_GPIO);
        host.rreg(IDX_GPIO_DIR, d);
        check(d, RST_GPIO_DIR);
        host.rreg(IDX_GPIO_DATA, d);
        check(d, RST_GPIO_DATA);
        host.rreg(IDX_GPIO_INV, d);
        check(d, RST_GPIO_INV);
        host.rd(PORT_INDEX_LO, d, v);
        check(d, READ_IDLE);
        check({7'b0, v}, 8'h01);
        foreach (rows[i]) begin
            gpio_in = rows[i].pin;
            host.wreg(IDX_GPIO_DIR, 8'h00);
            host.wreg(IDX_GPIO_DATA, rows[i].dw);
            host.wreg(IDX_GPIO_INV, rows[i].inv);
            host.wreg(IDX_GPIO_DIR, rows[i].dir);
            host.wreg(IDX_GPIO_DATA, 8'hff);
            host.rreg(IDX_GPIO_DATA, d);
            check(d, rows[i].rd);
            check(gpio_oe, rows[i].oe);
            check(gpio_out, rows[i].out);
        end
        // Locked write to the data port must leave the data register alone
        host.lock();
        host.rd(PORT_DATA_LO, d, v);
        check(d, READ_IDLE);
        host.wr(PORT_DATA_LO, 8'h00);
        host.unlock();
        host.rreg(IDX_GPIO_DATA, d);
        check(d, 8'hfc);
        check(gpio_out, 8'h33);
        // 20h is twenty ticks, not thirty-two
        host.logical_device_number(LDN_WDT);
        host.wreg(IDX_WDT_TMO, 8'h20);
        host.wreg(IDX_WDT_ACT, 8'h01);
        wait_rst(1'b1, 200, n);
        check(8'(n >= 20 * TICK - 4 && n <= 20 * TICK + 4), 8'h01);
        wait_rst(1'b0, 50, n);
        check(8'(n), 8'(RSTC));
        quiet(120);
        check({7'b0, hi}, 8'h00);
        host.rreg(IDX_WDT_ACT, d);
        check(d, 8'h01);
        host.wreg(IDX_WDT_TMO, 8'h02);
        wait_rst(1'b1, 40, n);
        check(8'(n >= 2 * TICK - 4), 8'h01);
        wait_rst(1'b0, 50, n);
        host.wreg(IDX_WDT_ACT, 8'h00);
        host.wreg(IDX_WDT_TMO, 8'h01);
        quiet(60);
        check({7'b0, hi}, 8'h00);
        // High strap moves both ports; the low pair goes deaf
        base_sel = 1'b1;
        do_reset();
        // Mid-run reset must drop driven pins and the last read answer
        check(gpio_oe, 8'h00);
        check(gpio_out, 8'h00);
        check(io_rdata, READ_IDLE);
        check({7'b0, cpu_rst}, 8'h00);
        host.unlock();
        host.rd(PORT_DATA_LO, d, v);
        check({7'b0, v}, 8'h00);
        host.logical_device_number(LDN_GPIO);
        host.rreg(IDX_GPIO_DIR, d);
        check(d, RST_GPIO_DIR);
        close_out();
    end
endmodule
